//--- core/pixel_write_control.sv
/*
  Pixel write-control stage with its AXI4-Lite register file. Takes one
  pixel from the iterators, applies clip, stipple, chroma key, alpha mask,
  depth test and write masks, and hands a write to the frame buffer port.
  Assumes iterators and frame buffer run on aclk; dst_depth and dst_color
  are valid with the pixel.
*/
`timescale 1ns/10ps
module pixel_write_control #(
    parameter logic [pixel_write_pkg::COORD_W-1:0] SCREEN_ROWS = 12'h1e0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [pixel_write_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pixel_write_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic [1:0] pix_kind,
    input wire logic [pixel_write_pkg::COORD_W-1:0] pix_x,
    input wire logic [pixel_write_pkg::COORD_W-1:0] pix_y,
    input wire logic [23:0] tex_rgb,
    input wire logic [23:0] pix_rgb,
    input wire logic [7:0] pix_alpha,
    input wire logic [31:0] iter_z,
    input wire logic [31:0] iter_w,
    input wire logic [15:0] dst_depth,
    input wire logic [15:0] dst_color,
    output logic fb_valid,
    input wire logic fb_ready,
    output logic [pixel_write_pkg::COORD_W-1:0] fb_x,
    output logic [pixel_write_pkg::COORD_W-1:0] fb_y,
    output logic [15:0] fb_color,
    output logic [15:0] fb_aux,
    output logic [23:0] fb_blend_dst,
    output logic fb_rgb_we,
    output logic fb_aux_we
);
    import pixel_write_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] mode;
        logic [31:0] stipple;
        logic [31:0] const_da;
        logic [31:0] clip_h;
        logic [31:0] clip_v;
        logic [31:0] key;
        logic [31:0] fail_cnt;
        logic [31:0] dwm;
        logic pix_ready;
        logic fb_valid;
        logic [COORD_W-1:0] fb_x;
        logic [COORD_W-1:0] fb_y;
        logic [15:0] fb_color;
        logic [15:0] fb_aux;
        logic [23:0] fb_blend_dst;
        logic fb_rgb_we;
        logic fb_aux_we;
    } state_s;

    state_s st;
    state_s next_st;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic in_range(input logic [COORD_W-1:0] v, input logic [31:0] bounds);
        return v >= bounds[CLIP_MIN_LSB +: COORD_W] && v <= bounds[CLIP_MAX_LSB +: COORD_W];
    endfunction : in_range

    logic accept;
    logic wr_go;
    logic bypass;
    logic is_fill;
    logic stip_kind;
    logic [7:0] stip_row;
    logic stip_bit;
    logic stip_kill;
    logic clip_kill;
    logic key_hit;
    logic alpha_kill;
    logic pix_ok;
    logic depth_pass;
    logic depth_ok;
    logic [15:0] write_depth;
    logic y_bottom;
    logic [15:0] color565;
    logic [23:0] blend_dst;

    assign accept = pix_valid && st.pix_ready;
    assign wr_go = st.aw_got && st.w_got;
    assign is_fill = pix_kind == PK_FILL;
    assign bypass = pix_kind == PK_DIRECT && !st.dwm[DWM_PIPE];
    assign stip_kind = pix_kind == PK_TRIANGLE || (pix_kind == PK_DIRECT && !bypass);

    // byte by row, bit by column
    assign stip_row = st.stipple[{pix_y[1:0], 3'h0} +: 8];
    assign stip_bit = stip_row[3'h7 - pix_x[2:0]];
    assign stip_kill = stip_kind && st.mode[B_STIP_EN]
                       && (st.mode[B_STIP_MODE] ? !stip_bit : !st.stipple[STIP_TOP]);
    assign clip_kill = st.mode[B_CLIP] && !(in_range(pix_x, st.clip_h) && in_range(pix_y, st.clip_v));
    assign key_hit = stip_kind && st.mode[B_CHROMA] && tex_rgb == st.key[23:0];
    assign alpha_kill = stip_kind && st.mode[B_AMASK] && !pix_alpha[0];
    assign pix_ok = !clip_kill && !stip_kill && !alpha_kill;
    assign depth_ok = !stip_kind || depth_pass;
    // origin from own register when bypassed
    assign y_bottom = bypass ? st.dwm[DWM_YORG] : st.mode[B_YORG];

    depth_stage u_depth (
        .mode(st.mode),
        .iter_z(iter_z),
        .iter_w(iter_w),
        .const_depth(st.const_da[15:0]),
        .dst_depth(dst_depth),
        .pass(depth_pass),
        .write_depth(write_depth)
    );

    color_dither u_dither (
        .rgb(pix_rgb),
        .px(pix_x[1:0]),
        .py(pix_y[1:0]),
        .enable(st.mode[B_DITHER]),
        .algo2(st.mode[B_DALGO]),
        .sub_en(st.mode[B_DSUB]),
        .dst_color(dst_color),
        .color565(color565),
        .blend_dst(blend_dst)
    );

    always_comb begin
        next_st = st;
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (st.fb_valid && fb_ready) begin
            next_st.fb_valid = 1'b0;
        end
        // pixel stage: one pixel held at a time, so ready is simply "output empty"
        if (accept) begin
            next_st.fb_valid = 1'b1;
            next_st.fb_x = pix_x;
            next_st.fb_y = y_bottom ? SCREEN_ROWS - 12'h001 - pix_y : pix_y;
            next_st.fb_color = color565;
            next_st.fb_blend_dst = blend_dst;
            next_st.fb_rgb_we = pix_ok && depth_ok && !key_hit && st.mode[B_RGB_WM];
            next_st.fb_aux_we = pix_ok && depth_ok && !bypass && st.mode[B_AUX_WM];
            if (st.mode[B_APLANES]) begin
                next_st.fb_aux = {8'h00, pix_alpha};
            end else if (is_fill) begin
                next_st.fb_aux = st.const_da[15:0];
            end else begin
                next_st.fb_aux = write_depth;
            end
            if (stip_kind && !st.mode[B_STIP_MODE]) begin
                next_st.stipple = {st.stipple[30:0], st.stipple[STIP_TOP]};
            end
        end
        // a software write to the stipple register beats the rotation in the same cycle
        if (wr_go) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            if (st.waddr == OFF_MODE) begin
                next_st.mode = merge(st.mode, st.wdata, st.wstrb) & MODE_WR_MASK;
            end else if (st.waddr == OFF_STIPPLE) begin
                next_st.stipple = merge(st.stipple, st.wdata, st.wstrb);
            end else if (st.waddr == OFF_CONST_DA) begin
                next_st.const_da = merge(st.const_da, st.wdata, st.wstrb);
            end else if (st.waddr == OFF_CLIP_H) begin
                next_st.clip_h = merge(st.clip_h, st.wdata, st.wstrb);
            end else if (st.waddr == OFF_CLIP_V) begin
                next_st.clip_v = merge(st.clip_v, st.wdata, st.wstrb);
            end else if (st.waddr == OFF_KEY) begin
                next_st.key = merge(st.key, st.wdata, st.wstrb);
            end else if (st.waddr == OFF_FAIL_CNT) begin
                next_st.fail_cnt = REG_RESET;
            end else if (st.waddr == OFF_DWM) begin
                next_st.dwm = merge(st.dwm, st.wdata, st.wstrb);
            end else begin
                next_st.bresp = RESP_SLVERR;
            end
        end
        // count after clear so the event wins
        if (accept && alpha_kill) begin
            next_st.fail_cnt = next_st.fail_cnt + 32'h00000001;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            if (s_axi_araddr == OFF_MODE) begin
                next_st.rdata = st.mode;
            end else if (s_axi_araddr == OFF_STIPPLE) begin
                next_st.rdata = st.stipple;
            end else if (s_axi_araddr == OFF_CONST_DA) begin
                next_st.rdata = st.const_da;
            end else if (s_axi_araddr == OFF_CLIP_H) begin
                next_st.rdata = st.clip_h;
            end else if (s_axi_araddr == OFF_CLIP_V) begin
                next_st.rdata = st.clip_v;
            end else if (s_axi_araddr == OFF_KEY) begin
                next_st.rdata = st.key;
            end else if (s_axi_araddr == OFF_FAIL_CNT) begin
                next_st.rdata = st.fail_cnt;
            end else if (s_axi_araddr == OFF_DWM) begin
                next_st.rdata = st.dwm;
            end else begin
                next_st.rdata = REG_RESET;
                next_st.rresp = RESP_SLVERR;
            end
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
        next_st.pix_ready = !next_st.fb_valid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;
    assign pix_ready = st.pix_ready;
    assign fb_valid = st.fb_valid;
    assign fb_x = st.fb_x;
    assign fb_y = st.fb_y;
    assign fb_color = st.fb_color;
    assign fb_aux = st.fb_aux;
    assign fb_blend_dst = st.fb_blend_dst;
    assign fb_rgb_we = st.fb_rgb_we;
    assign fb_aux_we = st.fb_aux_we;

    clip_outside_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        accept && st.mode[B_CLIP] && pix_x > st.clip_h[CLIP_MAX_LSB +: COORD_W] |=> !fb_rgb_we && !fb_aux_we)
        else $error("clipped pixel produced a write");

    chroma_block_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        accept && pix_kind == PK_TRIANGLE && st.mode[B_CHROMA] && tex_rgb == st.key[23:0] |=> fb_valid && !fb_rgb_we)
        else $error("chroma-keyed pixel reached the color buffer");

    stipple_rotate_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        accept && pix_kind == PK_TRIANGLE && !st.mode[B_STIP_MODE] && !wr_go
        |=> st.stipple == {$past(st.stipple[30:0]), $past(st.stipple[STIP_TOP])})
        else $error("stipple did not rotate by one");

    stipple_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        accept && st.mode[B_STIP_MODE] && !wr_go |=> $stable(st.stipple))
        else $error("stipple rotated in pattern mode");

    rgb_mask_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        accept && !st.mode[B_RGB_WM] |=> fb_valid && !fb_rgb_we)
        else $error("color write with RGB mask cleared");

    aux_mask_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        accept && !st.mode[B_AUX_WM] |=> fb_valid && !fb_aux_we)
        else $error("depth write with depth mask cleared");

    alpha_fail_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        accept && pix_kind == PK_TRIANGLE && st.mode[B_AMASK] && !pix_alpha[0] && !wr_go
        |=> st.fail_cnt == $past(st.fail_cnt) + 32'h00000001 && !fb_rgb_we && !fb_aux_we)
        else $error("alpha failure not counted or not blocked");

    never_pass_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        accept && pix_kind == PK_TRIANGLE && st.mode[B_DEPTH_EN] && st.mode[B_FUNC_LO +: 3] == DF_NEVER
        |=> !fb_rgb_we && !fb_aux_we)
        else $error("never function let a pixel through");

    write_resp_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing after address and data");
endmodule : pixel_write_control

//--- core/pixel_write_pkg.sv
/*
  Shared constants and types of the pixel write-control stage: register
  offsets, control bit positions, depth functions, pixel kinds and the
  ordered-dither matrices.
  Assumes a single 10 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
// Operation
// - clip enable discards pixels outside inclusive rectangle
// - chroma match blocks RGB buffer write
// - chroma compare uses texture lookup color
// - stipple enable gates; mode selects rotate/pattern
// - rotate mode: top bit zero kills pixel
// - rotate mode shifts pattern left every pixel
// - pattern mode picks byte by Y, bit by X
// - pattern mode zero bit kills; never rotates
// - depth enable compares using three-bit function
// - W select uses inverse W as 4.12 float
// - dither enable dithers, otherwise truncates to 16
// - algorithm bit picks 4x4 or 2x2 dither
// - cleared RGB mask suppresses all RGB writes
// - cleared depth mask suppresses all depth writes
// - alpha mask failure kills pixel, counts failure
// - bias adds constant depth to computed depth
// - Y origin bit flips rows; bypass uses own
// - alpha planes use aux buffer; depth disabled (code still applies the depth test when depth enable is set)
// - dither subtraction applied to destination before blending
// - compare source bit selects constant depth
// - depth buffer stores biased iterated depth
// - float select converts W or Z to 4.12
// - depth function codes never through always
// - RGB written only on pass with mask
package pixel_write_pkg;
    localparam int ADDR_W = 8;
    localparam int COORD_W = 12;
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STIPPLE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CONST_DA = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CLIP_H = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_CLIP_V = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_KEY = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_FAIL_CNT = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_DWM = 8'h1c;
    localparam logic [31:0] MODE_WR_MASK = 32'h003f3fff;
    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int B_CLIP = 0;
    localparam int B_CHROMA = 1;
    localparam int B_STIP_EN = 2;
    localparam int B_WSEL = 3;
    localparam int B_DEPTH_EN = 4;
    localparam int B_FUNC_LO = 5;
    localparam int B_DITHER = 8;
    localparam int B_RGB_WM = 9;
    localparam int B_AUX_WM = 10;
    localparam int B_DALGO = 11;
    localparam int B_STIP_MODE = 12;
    localparam int B_AMASK = 13;
    localparam int B_BIAS = 16;
    localparam int B_YORG = 17;
    localparam int B_APLANES = 18;
    localparam int B_DSUB = 19;
    localparam int B_CSRC = 20;
    localparam int B_FSEL = 21;
    localparam int DWM_PIPE = 8;
    localparam int DWM_YORG = 13;
    localparam int STIP_TOP = 31;
    localparam int CLIP_MAX_LSB = 0;
    localparam int CLIP_MIN_LSB = 16;
    localparam int ITER_HI = 31;
    localparam int ITER_LO = 16;
    localparam logic [63:0] DITHER4 = 64'h5d7f91b36e4ca280;
    localparam logic [15:0] DITHER2 = 16'h4c80;
    typedef enum logic [2:0] {
        DF_NEVER, DF_LESS, DF_EQUAL, DF_LEQUAL, DF_GREATER, DF_NOTEQUAL, DF_GEQUAL, DF_ALWAYS
    } depth_func_e;
    typedef enum logic [1:0] {PK_TRIANGLE, PK_FILL, PK_DIRECT} pixel_kind_e;
endpackage : pixel_write_pkg

//--- core/depth_stage.sv
/*
  Depth source selection, 4.12 float conversion, biasing and comparison.
  Purely combinational; the caller registers its results.
*/
`timescale 1ns/10ps
module depth_stage (
    input wire logic [31:0] mode,
    input wire logic [31:0] iter_z,
    input wire logic [31:0] iter_w,
    input wire logic [15:0] const_depth,
    input wire logic [15:0] dst_depth,
    output logic pass,
    output logic [15:0] write_depth
);
    import pixel_write_pkg::*;

    // leading-zero count is the exponent; the mantissa is inverted so that
    // the code rises as w grows smaller, i.e. tracks 1/w
    function automatic logic [15:0] to_float412(input logic [15:0] v);
        logic [15:0] sh;
        logic [3:0] lz;
        sh = v;
        lz = 4'h0;
        for (int i = 0; i < 15; i++) begin
            if (!sh[15]) begin
                sh = sh << 1;
                lz = lz + 4'h1;
            end
        end
        return {lz, ~sh[14:3]};
    endfunction : to_float412

    function automatic logic depth_test(input depth_func_e f, input logic [15:0] s, input logic [15:0] d);
        case (f)
            DF_NEVER: return 1'b0;
            DF_LESS: return s < d;
            DF_EQUAL: return s == d;
            DF_LEQUAL: return s <= d;
            DF_GREATER: return s > d;
            DF_NOTEQUAL: return s != d;
            DF_GEQUAL: return s >= d;
            default: return 1'b1;
        endcase
    endfunction : depth_test

    // bias wraps modulo 2^16
    function automatic logic [15:0] biased_sum(input logic [15:0] a, input logic [15:0] b);
        return a + b;
    endfunction : biased_sum

    logic [15:0] base;
    logic [15:0] biased;
    logic [15:0] cmp_src;

    assign base = mode[B_WSEL] ? to_float412(mode[B_FSEL] ? iter_z[ITER_HI:ITER_LO] : iter_w[ITER_HI:ITER_LO])
                               : iter_z[ITER_HI:ITER_LO];
    assign biased = mode[B_BIAS] ? biased_sum(base, const_depth) : base;
    assign cmp_src = mode[B_CSRC] ? const_depth : biased;
    assign pass = !mode[B_DEPTH_EN] || depth_test(depth_func_e'(mode[B_FUNC_LO +: 3]), cmp_src, dst_depth);
    assign write_depth = biased;
endmodule : depth_stage

//--- core/color_dither.sv
/*
  24-to-16-bit color reduction with ordered dither, and dither subtraction
  on the destination color. Combinational; the caller registers results.
*/
`timescale 1ns/10ps
module color_dither (
    input wire logic [23:0] rgb,
    input wire logic [1:0] px,
    input wire logic [1:0] py,
    input wire logic enable,
    input wire logic algo2,
    input wire logic sub_en,
    input wire logic [15:0] dst_color,
    output logic [15:0] color565,
    output logic [23:0] blend_dst
);
    import pixel_write_pkg::*;

    function automatic logic [7:0] sat_add(input logic [7:0] c, input logic [3:0] a);
        logic [8:0] s;
        s = {1'b0, c} + {5'h00, a};
        return s[8] ? 8'hff : s[7:0];
    endfunction : sat_add

    function automatic logic [7:0] sat_sub(input logic [7:0] c, input logic [3:0] a);
        return (c > {4'h0, a}) ? c - {4'h0, a} : 8'h00;
    endfunction : sat_sub

    logic [3:0] matrix;
    logic [3:0] d;
    logic [7:0] r8;
    logic [7:0] g8;
    logic [7:0] b8;
    logic [7:0] r_sum;
    logic [7:0] g_sum;
    logic [7:0] b_sum;

    assign matrix = algo2 ? DITHER2[{py[0], px[0], 2'h0} +: 4] : DITHER4[{py, px, 2'h0} +: 4];
    assign d = enable ? matrix : 4'h0;
    assign r_sum = sat_add(rgb[23:16], {1'b0, d[3:1]});
    assign g_sum = sat_add(rgb[15:8], {2'h0, d[3:2]});
    assign b_sum = sat_add(rgb[7:0], {1'b0, d[3:1]});
    assign color565 = {r_sum[7:3], g_sum[7:2], b_sum[7:3]};
    assign r8 = {dst_color[15:11], dst_color[15:13]};
    assign g8 = {dst_color[10:5], dst_color[10:9]};
    assign b8 = {dst_color[4:0], dst_color[4:2]};
    assign blend_dst = sub_en ? {sat_sub(r8, {1'b0, matrix[3:1]}), sat_sub(g8, {2'h0, matrix[3:2]}),
                                 sat_sub(b8, {1'b0, matrix[3:1]})} : {r8, g8, b8};
endmodule : color_dither

//--- tb/fb_sink.sv
/*
  Frame buffer side of the pixel write stage: accepts each write,
  optionally after a stall. Assumes fb_valid holds until fb_ready.
*/
`timescale 1ns/10ps
module fb_sink (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fb_valid,
    input wire logic slow,
    output logic fb_ready
);
    logic [1:0] wait_cnt;
    // slow mode stalls three cycles so fb_* must hold across them
    always_ff @(posedge aclk) begin
        if (!aresetn || !fb_valid) begin
            wait_cnt <= 2'h0;
        end else begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
    assign fb_ready = !slow || (wait_cnt == 2'h3);
endmodule : fb_sink

//--- tb/tb_top.sv
/*
  Self-checking bench for pixel_write_control with fb_sink as the frame
  buffer. Assumes register offsets and reset values of pixel_write_pkg.
*/
`timescale 1ns/10ps
module tb_top;
    import pixel_write_pkg::*;
    localparam logic [7:0] PASS_BY_FUNC = 8'hcc;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic pix_valid = 1'b0, slow = 1'b0, pix_ready, fb_valid, fb_ready, awr, wr, bv, arr, rv, rgb_we, aux_we;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, alpha = 8'h1;
    logic [31:0] wdata = 32'h0, iter_z = 32'h1000_0000, rdata, q;
    logic [23:0] rgb = 24'h123456, fb_blend_dst, gb;
    logic [11:0] px_x = 12'h0, px_y = 12'h0, fb_y, gy, fb_x, gx;
    logic [15:0] dst_depth = 16'h1000, dst_color = 16'hffff, fb_aux, gaux, fb_color, gc;
    logic [1:0] bresp, rresp, r, kind = 2'h0;
    int fails = 0, checks = 0;
    // mode, alpha, expected {rgb_we, aux_we}
    logic [41:0] rows [5] = '{{32'h0, 8'h1, 2'b00}, {32'h200, 8'h1, 2'b10}, {32'h400, 8'h1, 2'b01},
        {32'h2600, 8'h0, 2'b00}, {32'h2600, 8'h1, 2'b11}};
    always #50 aclk = ~aclk;
    pixel_write_control DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_kind(kind), .pix_x(px_x),
        .pix_y(px_y), .tex_rgb(rgb), .pix_rgb(rgb), .pix_alpha(alpha), .iter_z(iter_z), .iter_w(iter_z),
        .dst_depth(dst_depth), .dst_color(dst_color), .fb_valid(fb_valid), .fb_ready(fb_ready), .fb_x(fb_x),
        .fb_y(fb_y), .fb_color(fb_color), .fb_aux(fb_aux), .fb_blend_dst(fb_blend_dst), .fb_rgb_we(rgb_we),
        .fb_aux_we(aux_we));
    fb_sink partner (.aclk(aclk), .aresetn(aresetn), .fb_valid(fb_valid), .slow(slow), .fb_ready(fb_ready));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awv <= w;
        wv <= w;
        arv <= !w;
        bready <= w;
        rready <= !w;
        do begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (arv && arr) arv <= 1'b0;
        end while (!(w ? bv : rv));
        q = rdata;
        r = w ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
    endtask : bus
    // sampled at negedge so the handshake edge's own updates cannot race
    task automatic px(input logic [11:0] x, input logic [11:0] y, input logic [1:0] exp_we);
        @(posedge aclk);
        px_x <= x;
        px_y <= y;
        pix_valid <= 1'b1;
        do @(posedge aclk); while (!pix_ready);
        pix_valid <= 1'b0;
        do @(negedge aclk); while (!(fb_valid && fb_ready));
        gy = fb_y;
        gaux = fb_aux;
        gx = fb_x;
        gc = fb_color;
        gb = fb_blend_dst;
        chk({rgb_we, aux_we}, exp_we);
        @(posedge aclk);
    endtask : px
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, OFF_MODE, rows[i][41:10]);
            alpha <= rows[i][9:2];
            px(12'h1, 12'h1, rows[i][1:0]);
        end
        bus(1'b0, OFF_FAIL_CNT, 32'h0);
        chk(q, 32'h1);
        $display("test masks done");
        for (int f = 0; f < 8; f++) begin
            bus(1'b1, OFF_MODE, 32'h610 | (f << 5));
            px(12'h1, 12'h1, {2{PASS_BY_FUNC[f]}});
        end
        bus(1'b1, OFF_CONST_DA, 32'hffff);
        bus(1'b1, OFF_MODE, 32'h10630);
        px(12'h1, 12'h1, 2'b11);
        chk(gaux, 16'h0fff);
        bus(1'b1, OFF_MODE, 32'h110630);
        px(12'h1, 12'h1, 2'b00);
        bus(1'b1, OFF_MODE, 32'h608);
        px(12'h1, 12'h1, 2'b11);
        chk(gaux, 16'h3fff);
        $display("test depth done");
        bus(1'b1, OFF_CLIP_H, 32'h10);
        bus(1'b1, OFF_CLIP_V, 32'h10);
        chk(r, RESP_OKAY);
        bus(1'b1, OFF_MODE, 32'h601);
        px(12'h10, 12'h10, 2'b11);
        px(12'h11, 12'h3, 2'b00);
        bus(1'b1, OFF_MODE, 32'h20600);
        px(12'h1, 12'h5, 2'b11);
        chk(gy, 12'h1da);
        chk(gx, 12'h1);
        chk(gc, 16'h11aa);
        chk(gb, 24'hffffff);
        // bypassed direct write follows its own origin bit, which is clear
        kind <= 2'h2;
        px(12'h1, 12'h5, 2'b10);
        chk(gy, 12'h5);
        kind <= 2'h1;
        px(12'h1, 12'h5, 2'b11);
        chk(gy, 12'h1da);
        chk(gaux, 16'hffff);
        kind <= 2'h0;
        slow <= 1'b1;
        bus(1'b1, OFF_STIPPLE, 32'h4000_0000);
        bus(1'b1, OFF_MODE, 32'h604);
        px(12'h1, 12'h1, 2'b00);
        px(12'h1, 12'h1, 2'b11);
        bus(1'b1, OFF_MODE, 32'h1604);
        px(12'h7, 12'h0, 2'b11);
        px(12'h0, 12'h0, 2'b00);
        $display("test clip origin stipple done");
        bus(1'b1, OFF_KEY, 32'h123456);
        bus(1'b1, OFF_MODE, 32'h602);
        px(12'h1, 12'h1, 2'b01);
        // depth enable is clear, so no depth test runs while alpha planes are on
        bus(1'b1, OFF_MODE, 32'h40600);
        px(12'h1, 12'h1, 2'b11);
        chk(gaux, 16'h0001);
        bus(1'b1, OFF_MODE, 32'h80700);
        px(12'h1, 12'h1, 2'b11);
        chk(gc, 16'h11ab);
        chk(gb, 24'hfdfefd);
        bus(1'b1, OFF_MODE, 32'h80f00);
        px(12'h2, 12'h1, 2'b11);
        chk(gc, 16'h19ab);
        chk(gb, 24'hf9fcf9);
        $display("test chroma alpha dither done");
        bus(1'b1, OFF_MODE, 32'hffff_ffff);
        bus(1'b0, OFF_MODE, 32'h0);
        chk(q, MODE_WR_MASK);
        bus(1'b0, 8'h40, 32'h0);
        chk(r, RESP_SLVERR);
        $display("test registers done");
        report_and_stop();
    end
    initial begin
        #2_000_000;
        fails++;
        report_and_stop();
    end
endmodule : tb_top
